// ===== pkg/plosc_pkg.sv
// Functional notes
// - both logic outputs low from power-up
// - instruction byte carries both output states
// - instruction alone leaves stored wipers untouched unless its centre bit is set
// - address plus instruction then stop updates outputs
// - new transaction after stop applies outputs
// - repeated start accepts address and instruction
// - shutdown from pin or soft bit
// - next command restores soft-shutdown wiper
// - programming accepted while pin holds shutdown
// - pin release applies latest programmed settings
// - address is 01011 plus two strap bits
// - instruction bit order chan, center, sd, out2, out1
// - shutdown opens terminal a, wiper to b
package plosc_pkg;

    // slave address layout
    localparam logic [4:0] ADDR_FIXED   = 5'h0b;
    localparam int         ADDR_WIDTH   = 7;

    // instruction byte field positions
    localparam int         BIT_CHAN     = 7;
    localparam int         BIT_CENTER   = 6;
    localparam int         BIT_SD       = 5;
    localparam int         BIT_OUT2     = 4;
    localparam int         BIT_OUT1     = 3;

    // reset and preset values
    localparam logic       OUT_RESET    = 1'b0;
    localparam logic [7:0] WIPER_RESET  = 8'h80;
    localparam logic [7:0] WIPER_CENTER = 8'h80;
    localparam int         CHANNELS     = 2;

    // serial clock timing, quarter period rounded up
    localparam int         CLK_NS       = 4;
    localparam int         SCL_PERIOD_NS = 10000;
    localparam int         QTR_CYCLES   =
        (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;

    // device receiver states
    typedef enum logic [3:0] {
        PLOSC_D_IDLE     = 4'h0,
        PLOSC_D_ADDR     = 4'h1,
        PLOSC_D_ADDR_ACK = 4'h2,
        PLOSC_D_INSTR    = 4'h3,
        PLOSC_D_INSTR_ACK = 4'h4,
        PLOSC_D_DATA     = 4'h5,
        PLOSC_D_DATA_ACK = 4'h6,
        PLOSC_D_READ     = 4'h7,
        PLOSC_D_READ_ACK = 4'h8
    } plosc_dstate_t;

    // host sequencer states
    typedef enum logic [2:0] {
        PLOSC_H_IDLE  = 3'h0,
        PLOSC_H_START = 3'h1,
        PLOSC_H_BYTE  = 3'h2,
        PLOSC_H_STOP  = 3'h3,
        PLOSC_H_HOLD  = 3'h4
    } plosc_hstate_t;

endpackage

// ===== pkg/plosc_if.sv
`timescale 1ns/100ps
`default_nettype none
// two-wire bus with pull-ups; every driver is open drain
interface plosc_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl_line;
    logic sda_line;

    // wired-and of all drivers against the pull-up
    assign scl_line = (host_scl_oe & ~host_scl_out) ? 1'b0 : 1'b1;
    assign sda_line = ((host_sda_oe & ~host_sda_out) |
                       (dev_sda_oe & ~dev_sda_out)) ? 1'b0 : 1'b1;

    modport host (
        output host_scl_out,
        output host_scl_oe,
        output host_sda_out,
        output host_sda_oe,
        input  scl_line,
        input  sda_line
    );

    modport dev (
        output dev_sda_out,
        output dev_sda_oe,
        input  scl_line,
        input  sda_line
    );
endinterface
`default_nettype wire

// ===== verilog/plosc_dev.sv
`timescale 1ns/100ps
`default_nettype none
module plosc_dev (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    plosc_if.dev             bus,
    input  wire logic        addr_strap_zero,
    input  wire logic        addr_strap_one,
    input  wire logic        shutdown_pin_n,
    output logic             aux_logic_out_1,
    output logic             aux_logic_out_2,
    output logic [7:0]       wiper_setting_0,
    output logic [7:0]       wiper_setting_1,
    output logic [1:0]       chan_shutdown
);

    typedef struct packed {
        logic                      scl_s1;
        logic                      scl_s2;
        logic                      scl_d;
        logic                      sda_s1;
        logic                      sda_s2;
        logic                      sda_d;
        logic                      shutdown_pin_n_s1;
        logic                      shutdown_pin_n_s2;
        logic [1:0]                strap_s1;
        logic [1:0]                strap_s2;
        plosc_pkg::plosc_dstate_t  st;
        logic [3:0]                bitcnt;
        logic [7:0]                shreg;
        logic                      rw;
        logic                      chan;
        logic                      sda_oe;
        logic                      out1;
        logic                      out2;
        logic [1:0][7:0]           wiper;
        logic [1:0]                soft_sd;
        logic [1:0]                shutdown_pin_n_out;
    } plosc_dev_t;

    plosc_dev_t state_reg;
    plosc_dev_t state_next;

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    logic addr_match;

    // bus conditions seen on the synchronised lines
    assign start_cond = state_reg.scl_s2 & state_reg.scl_d &
                        state_reg.sda_d & ~state_reg.sda_s2;
    assign stop_cond  = state_reg.scl_s2 & state_reg.scl_d &
                        ~state_reg.sda_d & state_reg.sda_s2;
    assign scl_rise   = state_reg.scl_s2 & ~state_reg.scl_d;
    assign scl_fall   = ~state_reg.scl_s2 & state_reg.scl_d;
    // fixed upper bits plus straps, strap one above strap zero
    assign addr_match = state_reg.shreg[7:1] ==
                        {plosc_pkg::ADDR_FIXED, state_reg.strap_s2};

    // next-state logic of the whole receiver
    always_comb begin
        state_next = state_reg;
        // two-stage synchronisers for every pin input
        state_next.scl_s1   = bus.scl_line;
        state_next.scl_s2   = state_reg.scl_s1;
        state_next.scl_d    = state_reg.scl_s2;
        state_next.sda_s1   = bus.sda_line;
        state_next.sda_s2   = state_reg.sda_s1;
        state_next.sda_d    = state_reg.sda_s2;
        state_next.shutdown_pin_n_s1  = shutdown_pin_n;
        state_next.shutdown_pin_n_s2  = state_reg.shutdown_pin_n_s1;
        state_next.strap_s1 = {addr_strap_one, addr_strap_zero};
        state_next.strap_s2 = state_reg.strap_s1;

        if (start_cond) begin
            // a repeated start also lands here from any state
            state_next.st     = plosc_pkg::PLOSC_D_ADDR;
            state_next.bitcnt = 4'h0;
            state_next.sda_oe = 1'b0;
        end else if (stop_cond) begin
            state_next.st     = plosc_pkg::PLOSC_D_IDLE;
            state_next.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (state_reg.st)
                plosc_pkg::PLOSC_D_ADDR,
                plosc_pkg::PLOSC_D_INSTR,
                plosc_pkg::PLOSC_D_DATA: begin
                    state_next.shreg  = {state_reg.shreg[6:0],
                                         state_reg.sda_s2};
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                end
                plosc_pkg::PLOSC_D_READ: begin
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                end
                plosc_pkg::PLOSC_D_READ_ACK: begin
                    // master not acknowledging ends the read
                    if (state_reg.sda_s2) begin
                        state_next.st = plosc_pkg::PLOSC_D_IDLE;
                    end
                end
                default: begin
                    state_next.bitcnt = state_reg.bitcnt;
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg.st)
                plosc_pkg::PLOSC_D_ADDR: begin
                    if (state_reg.bitcnt == 4'h8) begin
                        if (addr_match) begin
                            state_next.sda_oe = 1'b1;
                            state_next.rw     = state_reg.shreg[0];
                            state_next.st     = plosc_pkg::PLOSC_D_ADDR_ACK;
                        end else begin
                            state_next.st = plosc_pkg::PLOSC_D_IDLE;
                        end
                    end
                end
                plosc_pkg::PLOSC_D_ADDR_ACK: begin
                    state_next.bitcnt = 4'h0;
                    if (state_reg.rw) begin
                        // readback of the channel chosen last
                        state_next.shreg  = state_reg.wiper[state_reg.chan];
                        state_next.sda_oe =
                            ~state_reg.wiper[state_reg.chan][7];
                        state_next.st     = plosc_pkg::PLOSC_D_READ;
                    end else begin
                        // instruction is the second byte of a write
                        state_next.sda_oe = 1'b0;
                        state_next.st     = plosc_pkg::PLOSC_D_INSTR;
                    end
                end
                plosc_pkg::PLOSC_D_INSTR: begin
                    if (state_reg.bitcnt == 4'h8) begin
                        state_next.sda_oe = 1'b1;
                        state_next.st     = plosc_pkg::PLOSC_D_INSTR_ACK;
                        // outputs change only on an acknowledged instruction
                        state_next.out1 =
                            state_reg.shreg[plosc_pkg::BIT_OUT1];
                        state_next.out2 =
                            state_reg.shreg[plosc_pkg::BIT_OUT2];
                        state_next.chan =
                            state_reg.shreg[plosc_pkg::BIT_CHAN];
                        // any new command lifts soft shutdown first
                        state_next.soft_sd = 2'h0;
                        state_next.soft_sd[state_reg.shreg[
                            plosc_pkg::BIT_CHAN]] =
                            state_reg.shreg[plosc_pkg::BIT_SD];
                        // wiper only moves on the centre bit, else kept
                        if (state_reg.shreg[plosc_pkg::BIT_CENTER]) begin
                            state_next.wiper[state_reg.shreg[
                                plosc_pkg::BIT_CHAN]] =
                                plosc_pkg::WIPER_CENTER;
                        end
                    end
                end
                plosc_pkg::PLOSC_D_INSTR_ACK,
                plosc_pkg::PLOSC_D_DATA_ACK: begin
                    state_next.sda_oe = 1'b0;
                    state_next.bitcnt = 4'h0;
                    state_next.st     = plosc_pkg::PLOSC_D_DATA;
                end
                plosc_pkg::PLOSC_D_DATA: begin
                    if (state_reg.bitcnt == 4'h8) begin
                        // data byte loads the wiper of the chosen channel, replacing any centre preset
                        state_next.sda_oe = 1'b1;
                        state_next.wiper[state_reg.chan] =
                            state_reg.shreg;
                        state_next.st     = plosc_pkg::PLOSC_D_DATA_ACK;
                    end
                end
                plosc_pkg::PLOSC_D_READ: begin
                    if (state_reg.bitcnt == 4'h8) begin
                        state_next.sda_oe = 1'b0;
                        state_next.st     = plosc_pkg::PLOSC_D_READ_ACK;
                    end else begin
                        state_next.sda_oe = ~state_reg.shreg[6];
                        state_next.shreg  = {state_reg.shreg[6:0], 1'b0};
                    end
                end
                plosc_pkg::PLOSC_D_READ_ACK: begin
                    // acknowledged: send the same value again
                    state_next.bitcnt = 4'h0;
                    state_next.shreg  = state_reg.wiper[state_reg.chan];
                    state_next.sda_oe = ~state_reg.wiper[state_reg.chan][7];
                    state_next.st     = plosc_pkg::PLOSC_D_READ;
                end
                default: begin
                    state_next.sda_oe = 1'b0;
                end
            endcase
        end

        // pin low or soft bit opens terminal a and grounds the wiper
        for (int i = 0; i < plosc_pkg::CHANNELS; i++) begin
            state_next.shutdown_pin_n_out[i] =
                state_reg.soft_sd[i] | ~state_reg.shutdown_pin_n_s2;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg          <= '0;
            state_reg.scl_s1   <= 1'b1;
            state_reg.scl_s2   <= 1'b1;
            state_reg.scl_d    <= 1'b1;
            state_reg.sda_s1   <= 1'b1;
            state_reg.sda_s2   <= 1'b1;
            state_reg.sda_d    <= 1'b1;
            state_reg.shutdown_pin_n_s1  <= 1'b1;
            state_reg.shutdown_pin_n_s2  <= 1'b1;
            state_reg.st       <= plosc_pkg::PLOSC_D_IDLE;
            state_reg.out1     <= plosc_pkg::OUT_RESET;
            state_reg.out2     <= plosc_pkg::OUT_RESET;
            state_reg.wiper[0] <= plosc_pkg::WIPER_RESET;
            state_reg.wiper[1] <= plosc_pkg::WIPER_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs taken straight from the state register, except the sda data bit which is tied low
    assign bus.dev_sda_out     = 1'b0;
    assign bus.dev_sda_oe      = state_reg.sda_oe;
    assign aux_logic_out_1     = state_reg.out1;
    assign aux_logic_out_2     = state_reg.out2;
    assign wiper_setting_0     = state_reg.wiper[0];
    assign wiper_setting_1     = state_reg.wiper[1];
    assign chan_shutdown       = state_reg.shutdown_pin_n_out;

endmodule
`default_nettype wire

// ===== verilog/plosc_host.sv
`timescale 1ns/100ps
`default_nettype none
module plosc_host #(
    parameter int QTR = plosc_pkg::QTR_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    plosc_if.host            bus,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_read,
    input  wire logic [1:0]  req_strap,
    input  wire logic [7:0]  req_instr,
    input  wire logic        req_has_data,
    input  wire logic [7:0]  req_data,
    input  wire logic        req_hold,
    output logic             done,
    output logic             ack_err,
    output logic [7:0]       rd_data
);

    // refuse quarter counts the sequencer cannot serve
    if (QTR < 2 || QTR > 65535) begin : g_bad_qtr
        $error("plosc_host: QTR out of range");
    end

    typedef struct packed {
        plosc_pkg::plosc_hstate_t st;
        logic [15:0]              qcnt;
        logic [1:0]               phase;
        logic [3:0]               bitn;
        logic [1:0]               byte_idx;
        logic [7:0]               shreg;
        logic                     sda_s1;
        logic                     sda_s2;
        logic                     scl_lo;
        logic                     sda_lo;
        logic                     is_read;
        logic                     has_data;
        logic                     hold;
        logic [7:0]               instr;
        logic [7:0]               data;
        logic                     ready;
        logic                     done;
        logic                     err;
        logic [7:0]               rd;
    } plosc_host_t;

    plosc_host_t state_reg;
    plosc_host_t state_next;
    logic        tick;
    logic        rd_byte;

    assign tick    = state_reg.qcnt == 16'(QTR - 1);
    assign rd_byte = state_reg.is_read & (state_reg.byte_idx == 2'h1);

    // quarter-period sequencer for start, bytes and stop
    always_comb begin
        state_next        = state_reg;
        state_next.done   = 1'b0;
        state_next.sda_s1 = bus.sda_line;
        state_next.sda_s2 = state_reg.sda_s1;
        state_next.qcnt   = tick ? 16'h0 : state_reg.qcnt + 16'h1;
        case (state_reg.st)
            plosc_pkg::PLOSC_H_IDLE,
            plosc_pkg::PLOSC_H_HOLD: begin
                state_next.qcnt = 16'h0;
                if (req_valid & state_reg.ready) begin
                    state_next.ready    = 1'b0;
                    state_next.err      = 1'b0;
                    state_next.is_read  = req_read;
                    state_next.has_data = req_has_data;
                    state_next.hold     = req_hold;
                    state_next.instr    = req_instr;
                    state_next.data     = req_data;
                    state_next.shreg    = {plosc_pkg::ADDR_FIXED, req_strap,
                                           req_read};
                    state_next.bitn     = 4'h0;
                    state_next.byte_idx = 2'h0;
                    // from idle skip straight to the falling data edge
                    state_next.phase    =
                        (state_reg.st == plosc_pkg::PLOSC_H_IDLE) ? 2'h2 :
                        2'h0;
                    state_next.st       = plosc_pkg::PLOSC_H_START;
                end
            end
            plosc_pkg::PLOSC_H_START: begin
                if (tick) begin
                    state_next.phase = state_reg.phase + 2'h1;
                    case (state_reg.phase)
                        2'h0: state_next.sda_lo = 1'b0;
                        2'h1: state_next.scl_lo = 1'b0;
                        2'h2: state_next.sda_lo = 1'b1;
                        default: begin
                            state_next.scl_lo = 1'b1;
                            state_next.st     = plosc_pkg::PLOSC_H_BYTE;
                        end
                    endcase
                end
            end
            plosc_pkg::PLOSC_H_BYTE: begin
                if (tick) begin
                    state_next.phase = state_reg.phase + 2'h1;
                    case (state_reg.phase)
                        2'h0: state_next.sda_lo = (state_reg.bitn < 4'h8) &
                                                  ~rd_byte &
                                                  ~state_reg.shreg[7];
                        2'h1: state_next.scl_lo = 1'b0;
                        2'h2: begin
                            if (state_reg.bitn < 4'h8) begin
                                state_next.shreg = {state_reg.shreg[6:0],
                                                    state_reg.sda_s2};
                            end else if (rd_byte) begin
                                state_next.rd = state_reg.shreg;
                            end else if (state_reg.sda_s2) begin
                                state_next.err = 1'b1;
                            end
                        end
                        default: begin
                            state_next.scl_lo = 1'b1;
                            state_next.bitn   = state_reg.bitn + 4'h1;
                            if (state_reg.bitn == 4'h8) begin
                                state_next.bitn     = 4'h0;
                                state_next.byte_idx = state_reg.byte_idx + 2'h1;
                                state_next.shreg    =
                                    (state_reg.byte_idx == 2'h0) ?
                                    state_reg.instr : state_reg.data;
                                // instruction only ends before data byte
                                if (state_reg.err | rd_byte |
                                    (state_reg.byte_idx == 2'h2) |
                                    ((state_reg.byte_idx == 2'h1) &
                                     ~state_reg.has_data)) begin
                                    if (state_reg.hold & ~state_reg.err &
                                        ~state_reg.is_read) begin
                                        state_next.st    =
                                            plosc_pkg::PLOSC_H_HOLD;
                                        state_next.ready = 1'b1;
                                        state_next.done  = 1'b1;
                                    end else begin
                                        state_next.st    =
                                            plosc_pkg::PLOSC_H_STOP;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            plosc_pkg::PLOSC_H_STOP: begin
                if (tick) begin
                    state_next.phase = state_reg.phase + 2'h1;
                    case (state_reg.phase)
                        2'h0: state_next.sda_lo = 1'b1;
                        2'h1: state_next.scl_lo = 1'b0;
                        2'h2: state_next.sda_lo = 1'b0;
                        default: begin
                            state_next.st    = plosc_pkg::PLOSC_H_IDLE;
                            state_next.ready = 1'b1;
                            state_next.done  = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                state_next.st = plosc_pkg::PLOSC_H_IDLE;
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg        <= '0;
            state_reg.st     <= plosc_pkg::PLOSC_H_IDLE;
            state_reg.sda_s1 <= 1'b1;
            state_reg.sda_s2 <= 1'b1;
            state_reg.ready  <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.host_scl_out = 1'b0;
    assign bus.host_scl_oe  = state_reg.scl_lo;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe  = state_reg.sda_lo;
    assign req_ready        = state_reg.ready;
    assign done             = state_reg.done;
    assign ack_err          = state_reg.err;
    assign rd_data          = state_reg.rd;

endmodule
`default_nettype wire

// ===== sim/plosc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module plosc_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl_line
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // bus drivers quiet after reset, framing and bit timing on the wire
    property p_rel; disable iff (1'b0)
        $fell(srst) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe; endproperty
    a_rel: assert property (p_rel) else $error("driver on after reset");
    property p_ack; $rose(dev_sda_oe) |-> !scl_line; endproperty
    a_ack: assert property (p_ack) else $error("device drove on high");
    property p_hi; scl_line && $past(scl_line) |-> $stable(dev_sda_oe); endproperty
    a_hi: assert property (p_hi) else $error("device moved on high");
    property p_len; $rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe; endproperty
    a_len: assert property (p_len) else $error("device never let go");
    property p_start; $rose(host_sda_oe) && scl_line |-> ##[1:20] !scl_line;
    endproperty
    a_start: assert property (p_start) else $error("start not framed");
    property p_stop; $fell(host_sda_oe) && scl_line |->
        !dev_sda_oe ##1 scl_line[*8]; endproperty
    a_stop: assert property (p_stop) else $error("stop not framed");
    property p_sh; $rose(scl_line) |-> scl_line[*8]; endproperty
    a_sh: assert property (p_sh) else $error("clock high too short");
    property p_sl; $fell(scl_line) |-> (!scl_line)[*8]; endproperty
    a_sl: assert property (p_sl) else $error("clock low too short");
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property ($rose(host_sda_oe) && scl_line);
    c_stop: cover property ($fell(host_sda_oe) && scl_line);
endmodule
`default_nettype wire

// ===== sim/test_pot_logic_out_shutdown_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_pot_logic_out_shutdown_ctrl;
    logic        clk_sys, srst, req_valid, req_ready, req_read, req_has_data;
    logic        req_hold, done, ack_err, aux_logic_out_1, aux_logic_out_2;
    logic        shutdown_pin_n, e_o1, e_o2, e_chan;
    logic [1:0]  req_strap, chan_shutdown, e_sd, strap;
    logic [7:0]  req_instr, req_data, rd_data, wiper_setting_0;
    logic [7:0]  wiper_setting_1, e_rd;
    logic [7:0]  e_w [2];
    logic [29:0] q [$];
    int          seed, err_total, n_checks;
    plosc_if bus_if ();
    plosc_dev plosc_dev_inst (.clk_sys, .srst, .bus(bus_if.dev),
        .addr_strap_zero(strap[0]), .addr_strap_one(strap[1]),
        .shutdown_pin_n, .aux_logic_out_1, .aux_logic_out_2,
        .wiper_setting_0, .wiper_setting_1, .chan_shutdown);
    plosc_host #(.QTR(8)) plosc_host_inst (.clk_sys, .srst,
        .bus(bus_if.host), .req_valid, .req_ready, .req_read, .req_strap,
        .req_instr, .req_has_data, .req_data, .req_hold, .done, .ack_err,
        .rd_data);
    plosc_chk plosc_chk_inst (.clk_sys, .srst,
        .host_scl_oe(bus_if.host_scl_oe), .host_sda_oe(bus_if.host_sda_oe),
        .dev_sda_oe(bus_if.dev_sda_oe), .scl_line(bus_if.scl_line));
    // observed and expected result words
    function automatic logic [29:0] cur();
        return {req_ready, ack_err, rd_data, aux_logic_out_2,
                aux_logic_out_1, wiper_setting_1, wiper_setting_0,
                chan_shutdown};
    endfunction
    // host is ready again in the cycle that reports completion
    function automatic logic [29:0] ex(input logic ae);
        return {1'b1, ae, e_rd, e_o2, e_o1, e_w[1], e_w[0],
                e_sd | {2{~shutdown_pin_n}}};
    endfunction
    task automatic chk(input logic [29:0] e, input logic [29:0] g);
        if (e[27:20] === 8'hxx) g[27:20] = 8'hxx; // no read done yet
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one request to the host, expectation noted first
    task automatic xfer(input logic rd, hd, hl, input logic [1:0] st,
                        input logic [7:0] ins, dt);
        @(posedge clk_sys);
        if (!rd && st == strap) begin
            {e_chan, e_o2, e_o1} = {ins[7], ins[4], ins[3]};
            e_sd = 2'h0;
            e_sd[ins[7]] = ins[5];
            if (ins[6]) e_w[ins[7]] = plosc_pkg::WIPER_CENTER;
            if (hd) e_w[ins[7]] = dt;
        end
        if (rd) e_rd = e_w[e_chan];
        q.push_back(ex(st != strap));
        {req_read, req_has_data, req_hold} <= {rd, hd, hl};
        {req_strap, req_instr, req_data} <= {st, ins, dt};
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (int k = 0; k < 4000 && done !== 1'b1; k++) @(posedge clk_sys);
        if (done !== 1'b1) err_total++; // transfer never finished
    endtask
    // compare each finished transfer with the oldest note
    always @(posedge clk_sys) begin
        if (done === 1'b1 && q.size() > 0)
            chk(q.pop_front(), cur());
    end
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        close_out();
    end
    // reset, then mixed writes, reads, wrong addresses and pin shutdown
    initial begin
        seed = 94352;
        err_total = 0;
        n_checks = 0;
        {srst, req_valid, req_read, req_has_data, req_hold} = 5'h10;
        {req_strap, req_instr, req_data, shutdown_pin_n, strap} = 21'h6;
        {e_o1, e_o2, e_chan, e_sd, e_rd} = {5'h0, 8'hxx};
        e_w = '{plosc_pkg::WIPER_RESET, plosc_pkg::WIPER_RESET};
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(ex(1'b0), cur());
        for (int i = 0; i < 24; i++) begin
            shutdown_pin_n <= (i % 6 >= 3);
            // second strap pattern for the later half of the run
            if (i == 12) begin
                strap <= 2'h1;
                @(posedge clk_sys);
            end
            xfer(i % 4 == 1, i % 2 == 0, i % 3 == 1 && i % 4 != 1,
                 (i % 5 == 3 && i % 4 != 1) ? ~strap : strap,
                 8'($random(seed)), 8'($random(seed)));
        end
        repeat (2) @(posedge clk_sys);
        close_out();
    end
endmodule
`default_nettype wire
